// ===== ccwd_edge.sv
`timescale 1ns/100ps

module ccwd_edge (
    input  wire logic sys_clk,
    input  wire logic rst_sync_b,
    input  wire logic level,
    output logic      rise
);
    import ccwd_pkg::*;

    logic prev_q;

    // Previous level starts low, so a level already high after reset counts as a rise
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;

endmodule : ccwd_edge

// ===== ccwd_master.sv
`timescale 1ns/100ps

module ccwd_master (
    input  wire logic           sys_clk,
    output logic                cmd_wr,
    output ccwd_pkg::ccwd_cmd_t cmd_wdata
);
    import ccwd_pkg::*;

    logic        wdog_q;
    logic [15:0] last_q;

    initial begin
        cmd_wr    = 1'b0;
        cmd_wdata = ccwd_cmd_t'(16'h0000);
        wdog_q    = 1'b0;
        last_q    = 16'h0000;
    end

    // Watchdog flips on every word so a stuck echo shows
    task send(input logic [15:0] w);
        last_q     = {w[15:12], wdog_q, w[10:0]};
        wdog_q     = ~wdog_q;
        cmd_wr    <= 1'b1;
        cmd_wdata <= ccwd_cmd_t'(last_q);
        @(posedge sys_clk);
    endtask : send

    // Inverse on a released bus, so stale data cannot pass
    task idle();
        cmd_wr    <= 1'b0;
        cmd_wdata <= ccwd_cmd_t'(~last_q);
    endtask : idle
endmodule : ccwd_master

// ===== ccwd_pkg.sv
`include "ccwd_regs.svh"

package ccwd_pkg;

    // Command word layout, most significant field first
    typedef struct packed {
        logic [`CCWD_VSLOT_N-1:0] vendor;
        logic                     wdog;
        logic                     accept;
        logic [1:0]               rsv_9_8;
        logic                     fault_rst;
        logic [2:0]               rsv_6_4;
        logic                     start;
        logic                     qstop_n;
        logic                     rsv_1;
        logic                     permit;
    } ccwd_cmd_t;

    // Decoded commands towards the converter
    typedef struct packed {
        logic                     run_permit;
        logic                     quick_stop;
        logic                     modulate;
        logic                     fault_reset;
        logic [`CCWD_VSLOT_N-1:0] vendor_slot;
    } ccwd_ctrl_t;

    typedef enum logic [2:0] {
        CCWD_ST_STOP  = 3'b001,
        CCWD_ST_RUN   = 3'b010,
        CCWD_ST_QSTOP = 3'b100
    } ccwd_state_t;

endpackage : ccwd_pkg

// ===== ccwd_regs.svh
`ifndef CCWD_REGS_SVH
`define CCWD_REGS_SVH

// Width of the fieldbus command word and of the report word
`define CCWD_WORD_W      16
// Command word value held after reset
`define CCWD_CMD_RESET   16'h0000
// Reserved command bits 1, 4, 5, 6, 8 and 9
`define CCWD_RSV_MASK    16'h0372
// Report word bit that carries the outgoing watchdog
`define CCWD_RPT_WDOG    15
// Command word bit that carries the incoming watchdog
`define CCWD_CMD_WDOG    11
// Number of vendor-specific slots, bits 12 to 15
`define CCWD_VSLOT_N     4
// Reset level of the two-stage reset synchroniser
`define CCWD_RST_ASSERT  2'h0
// One bit shifted in per edge; a wider value would truncate the high stage away
`define CCWD_RST_SHIFT   1'h1

`endif

// ===== ccwd_top.sv
`timescale 1ns/100ps
`include "ccwd_regs.svh"

module ccwd_top (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire logic                     cmd_wr,
    input  wire ccwd_pkg::ccwd_cmd_t      cmd_wdata,
    input  wire logic                     start_on_edge,
    output logic [`CCWD_WORD_W-1:0]       cmd_rdata,
    output ccwd_pkg::ccwd_ctrl_t          ctrl,
    output logic [`CCWD_WORD_W-1:0]       report_word
);
    import ccwd_pkg::*;

    logic [1:0]              rst_sync_q;
    logic                    rst_sync_b;
    ccwd_cmd_t               held_q;
    ccwd_cmd_t               held_d;
    ccwd_cmd_t               masked_w;
    logic                    accept_w;
    logic                    wdog_q;
    logic                    wdog_d;
    logic                    wr_wdog_w;
    logic                    start_rise;
    logic                    fault_rise;
    logic                    ok_w;
    logic                    go_w;
    ccwd_state_t             state_q;
    ccwd_state_t             state_d;
    logic                    modulate_q;
    logic                    fault_reset_q;
    logic                    permit_q;
    logic                    qstop_q;
    logic [`CCWD_VSLOT_N-1:0] vendor_q;
    logic [`CCWD_VSLOT_N-1:0] held_vendor_w;

    // Async assert, synchronous release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= `CCWD_RST_ASSERT;
        end else begin
            rst_sync_q <= {rst_sync_q[0], `CCWD_RST_SHIFT};
        end
    end
    assign rst_sync_b = rst_sync_q[1];

    // Reserved bits are dropped on capture so they can never steer anything
    assign masked_w = ccwd_cmd_t'(cmd_wdata & ~`CCWD_RSV_MASK);
    assign accept_w = cmd_wr & cmd_wdata.accept;
    assign held_d   = accept_w ? masked_w : held_q;
    // Watchdog follows every write, accepted or not
    assign wr_wdog_w = cmd_wdata.wdog;
    assign wdog_d    = cmd_wr ? wr_wdog_w : wdog_q;

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            held_q <= ccwd_cmd_t'(`CCWD_CMD_RESET);
            wdog_q <= 1'b0;
        end else begin
            held_q <= held_d;
            wdog_q <= wdog_d;
        end
    end

    // Edges seen on the held word, so a refused write cannot fake an edge
    ccwd_edge u_start_edge (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .level      (held_q.start),
        .rise       (start_rise)
    );

    ccwd_edge u_fault_edge (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .level      (held_q.fault_rst),
        .rise       (fault_rise)
    );

    assign ok_w = held_q.permit & held_q.qstop_n;
    assign go_w = held_q.start & (start_on_edge ? start_rise : 1'b1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            CCWD_ST_STOP: begin
                if (!held_q.qstop_n) begin
                    state_d = CCWD_ST_QSTOP;
                end else if (ok_w && go_w) begin
                    state_d = CCWD_ST_RUN;
                end
            end
            CCWD_ST_RUN: begin
                if (!held_q.qstop_n) begin
                    state_d = CCWD_ST_QSTOP;
                end else if (!held_q.permit || !held_q.start) begin
                    state_d = CCWD_ST_STOP;
                end
            end
            CCWD_ST_QSTOP: begin
                // Leave only to stop; in level mode a start still held then runs again, edge mode needs a fresh rise
                if (held_q.qstop_n) begin
                    state_d = CCWD_ST_STOP;
                end
            end
            default: begin
                state_d = CCWD_ST_STOP;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_q       <= CCWD_ST_STOP;
            modulate_q    <= 1'b0;
            fault_reset_q <= 1'b0;
            permit_q      <= 1'b0;
            qstop_q       <= 1'b0;
            vendor_q      <= '0;
        end else begin
            state_q       <= state_d;
            modulate_q    <= (state_d == CCWD_ST_RUN);
            fault_reset_q <= fault_rise;
            permit_q      <= held_q.permit;
            qstop_q       <= ~held_q.qstop_n;
            vendor_q      <= held_q.vendor;
        end
    end

    assign held_vendor_w = held_q.vendor;

    assign ctrl.run_permit  = permit_q;
    assign ctrl.quick_stop  = qstop_q;
    assign ctrl.modulate    = modulate_q;
    assign ctrl.fault_reset = fault_reset_q;
    assign ctrl.vendor_slot = vendor_q;

    // Readback shows the held word with the live watchdog overlaid
    assign cmd_rdata = {held_q[`CCWD_WORD_W-1:`CCWD_CMD_WDOG+1], wdog_q,
                        held_q[`CCWD_CMD_WDOG-1:0]};
    // Only the watchdog echo is built here; other status bits read zero
    assign report_word = {wdog_q, {(`CCWD_WORD_W-1){1'b0}}};

    sequence s_fault_rise;
        !held_q.fault_rst ##1 held_q.fault_rst;
    endsequence

    sequence s_fault_pulse;
        fault_reset_q ##1 !fault_reset_q;
    endsequence

    property p_permit_blocks;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        !held_q.permit |=> !modulate_q && !ctrl.run_permit;
    endproperty
    a_permit_blocks: assert property (p_permit_blocks)
        else $error("Modulating without run permit");

    property p_quick_stop;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        !held_q.qstop_n |=> ctrl.quick_stop && !modulate_q;
    endproperty
    a_quick_stop: assert property (p_quick_stop)
        else $error("Quick stop not applied");

    property p_start_low;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        !held_q.start |=> !modulate_q;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("Modulating with start bit low");

    property p_level_start;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        !start_on_edge && ok_w && held_q.start && state_q == CCWD_ST_STOP |=> modulate_q;
    endproperty
    a_level_start: assert property (p_level_start)
        else $error("Level start did not start modulation");

    property p_edge_needed;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        start_on_edge && held_q.start && $past(held_q.start) && state_q == CCWD_ST_STOP
        |=> !modulate_q;
    endproperty
    a_edge_needed: assert property (p_edge_needed)
        else $error("Edge start mode started on steady level");

    property p_fault_pulse;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        s_fault_rise |=> s_fault_pulse;
    endproperty
    a_fault_pulse: assert property (p_fault_pulse)
        else $error("Fault reset not a single pulse on rising edge");

    property p_fault_level;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        held_q.fault_rst && $past(held_q.fault_rst) |=> !fault_reset_q;
    endproperty
    a_fault_level: assert property (p_fault_level)
        else $error("Fault reset issued on steady level");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        !accept_w |=> $stable(held_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Held word changed without accept");

    property p_accept;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        accept_w |=> held_q == $past(masked_w);
    endproperty
    a_accept: assert property (p_accept)
        else $error("Accepted word not captured");

    property p_wdog_live;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        cmd_wr |=> report_word[`CCWD_RPT_WDOG] == $past(cmd_wdata.wdog);
    endproperty
    a_wdog_live: assert property (p_wdog_live)
        else $error("Watchdog echo did not follow write");

    property p_vendor;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        1'b1 |=> ctrl.vendor_slot == $past(held_vendor_w);
    endproperty
    a_vendor: assert property (p_vendor)
        else $error("Vendor slots not following held word");

    property p_rsv_zero;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (held_q & `CCWD_RSV_MASK) == `CCWD_CMD_RESET;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("Reserved bit held");

    property p_reset_zero;
        @(posedge sys_clk)
        $rose(rst_sync_b) |-> held_q == `CCWD_CMD_RESET && !modulate_q;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Held word not zero after reset");

endmodule : ccwd_top

// ===== converter_control_word_decoder_tb_top.sv
`timescale 1ns/100ps
`include "ccwd_regs.svh"

module converter_control_word_decoder_tb_top;
    import ccwd_pkg::*;

    logic        sys_clk;
    logic        rst_b;
    logic        cmd_wr;
    ccwd_cmd_t   cmd_wdata;
    logic        start_on_edge;
    logic [15:0] cmd_rdata;
    ccwd_ctrl_t  ctrl;
    logic [15:0] report_word;
    logic [15:0] held;
    int          mismatches;
    int          checked;
    int          pulses;

    ccwd_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .start_on_edge(start_on_edge), .cmd_rdata(cmd_rdata),
        .ctrl(ctrl), .report_word(report_word));

    ccwd_master master_u (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Back to back when the previous word left the strobe high
    task wr(input logic [15:0] w, input logic mod, input int fr);
        logic [15:0] exp_rd;
        if (cmd_wr !== 1'b1) @(posedge sys_clk);
        master_u.send(w);
        master_u.idle();
        pulses = 0;
        repeat (4) begin
            @(negedge sys_clk);
            if (ctrl.fault_reset === 1'b1) pulses++;
        end
        if (w[10]) held = w & ~`CCWD_RSV_MASK;
        exp_rd = held;
        exp_rd[11] = master_u.last_q[11];
        check(cmd_rdata, exp_rd);
        check(report_word, {master_u.last_q[11], 15'h0000});
        check({8'h00, ctrl}, {8'h00, held[0], ~held[2], mod, 1'b0, held[15:12]});
        check(16'(pulses), 16'(fr));
    endtask : wr

    task t_reset();
        @(negedge sys_clk);
        check(cmd_rdata, 16'h0000);
        // All-zero held word has the quick stop bit low, so quick stop is on
        check({8'h00, ctrl}, {8'h00, held[0], ~held[2], 2'h0, held[15:12]});
        check(report_word, 16'h0000);
        $display("t_reset done");
    endtask : t_reset

    task t_level();
        wr(16'h077F, 1'b1, 0);
        wr(16'h040C, 1'b0, 0);
        wr(16'h040D, 1'b1, 0);
        wr(16'h0409, 1'b0, 0);
        wr(16'h040D, 1'b1, 0);
        $display("t_level done");
    endtask : t_level

    task t_hold();
        wr(16'hF08C, 1'b1, 0);
        wr(16'h7008, 1'b1, 0);
        $display("t_hold done");
    endtask : t_hold

    task t_vendor();
        for (int i = 0; i < 4; i++) begin
            wr(16'h0405 | (16'h1000 << i), 1'b0, 0);
        end
        $display("t_vendor done");
    endtask : t_vendor

    task t_fault();
        wr(16'h0485, 1'b0, 1);
        wr(16'h0485, 1'b0, 0);
        @(posedge sys_clk);
        master_u.send(16'h0405);
        wr(16'h0485, 1'b0, 1);
        $display("t_fault done");
    endtask : t_fault

    // Level held high is not a start in edge mode
    task t_edge();
        @(posedge sys_clk);
        start_on_edge <= 1'b1;
        wr(16'h0409, 1'b0, 0);
        wr(16'h040D, 1'b0, 0);
        wr(16'h0405, 1'b0, 0);
        wr(16'h040D, 1'b1, 0);
        $display("t_edge done");
    endtask : t_edge

    task give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        rst_b         = 1'b0;
        start_on_edge = 1'b0;
        held          = 16'h0000;
        mismatches    = 0;
        checked       = 0;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_level();
        t_hold();
        t_vendor();
        t_fault();
        t_edge();
        give_verdict();
    end
endmodule : converter_control_word_decoder_tb_top
